/* File: inc/haptic_pkg.sv */
package haptic_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FAULT_STATUS_ADDR = 8'h00;
    localparam logic [7:0] MODE_CONTROL_ADDR = 8'h01;
    localparam logic [7:0] DIRECT_AMP_ADDR = 8'h02;
    localparam logic [7:0] SEQ_FIRST_ADDR = 8'h04;
    localparam logic [7:0] SEQ_LAST_ADDR = 8'h0b;
    localparam logic [7:0] FIRE_CONTROL_ADDR = 8'h0c;
    localparam logic [7:0] CFG_FIRST_ADDR = 8'h16;
    localparam logic [7:0] CFG_LAST_ADDR = 8'h1a;
    localparam logic [7:0] OTP_CONTROL_ADDR = 8'h1e;
    localparam logic [7:0] SUPPLY_LEVEL_ADDR = 8'h21;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SHORT_BIT = 0;
    localparam int THERMAL_BIT = 1;
    localparam int STANDBY_BIT = 6;
    localparam int SOFT_RESET_BIT = 7;
    localparam int FIRE_BIT = 0;
    localparam int OTP_PROGRAM_BIT = 0;
    localparam int WAIT_BIT = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_CONTROL_RESET = 8'h40;
    localparam logic [7:0] DIRECT_AMP_RESET = 8'h00;
    localparam logic [7:0] SEQ_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] SUPPLY_RESET = 8'h00;
    localparam logic [7:0] FULL_SCALE = 8'hff;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned STEP_TIME_MS = 5;
    localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * STEP_TIME_MS;
    localparam int unsigned POLL_TIME_MS = 1;
    localparam int unsigned POLL_CYCLES = CLK_HZ / 1000 * POLL_TIME_MS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_INTERNAL = 3'b000,
        MODE_EDGE = 3'b001,
        MODE_LEVEL = 3'b010,
        MODE_ANALOG = 3'b011,
        MODE_AUDIO = 3'b100,
        MODE_DIRECT = 3'b101,
        MODE_DIAG = 3'b110,
        MODE_CAL = 3'b111
    } mode_t;

    typedef enum logic [1:0] {
        PWR_SHUTDOWN = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_READY = 2'b10,
        PWR_ACTIVE = 2'b11
    } pwr_t;

endpackage

/* File: inc/seq_if.sv */
`timescale 1ns/1ps
interface seq_if;
    logic go;
    logic [7:0][7:0] slot;
    logic busy;
    logic done;
    logic [7:0] amp;

    modport ctrl (output go, output slot, input busy, input done, input amp);
    modport seq (input go, input slot, output busy, output done, output amp);
endinterface

/* File: verilog/wave_sequencer.sv */
`timescale 1ns/1ps
module wave_sequencer #(
    parameter int unsigned STEP_CYCLES = haptic_pkg::STEP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    seq_if.seq sq
);
    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_PLAY = 1'b1
    } seq_state_t;

    localparam int DIV_W = $clog2(STEP_CYCLES + 1);

    // a wait slot counts in 10 ms units, two 5 ms steps each
    function automatic logic [7:0] units_of(input logic [7:0] s);
        units_of = s[haptic_pkg::WAIT_BIT] ? {s[6:0], 1'b0} : {1'b0, s[6:0]};
    endfunction

    seq_state_t state_q;
    logic [DIV_W-1:0] div_q;
    logic [2:0] idx_q;
    logic [7:0] units_q;
    logic go_q;
    logic done_q;

    wire go_rise = sq.go & ~go_q;
    wire step_en = (div_q == DIV_W'(STEP_CYCLES - 1));
    wire [7:0] cur_slot = sq.slot[idx_q];
    wire [2:0] next_idx = idx_q + 3'd1;
    wire last_slot = (idx_q == 3'd7) || (sq.slot[next_idx] == 8'h00);
    wire playing = (state_q == SEQ_PLAY);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            go_q <= 1'b0;
            div_q <= '0;
        end else begin
            go_q <= sq.go;
            div_q <= (!playing || step_en) ? '0 : div_q + DIV_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= SEQ_IDLE;
            idx_q <= 3'd0;
            units_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                SEQ_IDLE: begin
                    idx_q <= 3'd0;
                    if (go_rise) begin
                        if (sq.slot[0] == 8'h00) begin
                            done_q <= 1'b1;
                        end else begin
                            state_q <= SEQ_PLAY;
                            units_q <= units_of(sq.slot[0]);
                        end
                    end
                end
                SEQ_PLAY: begin
                    if (!sq.go) begin
                        state_q <= SEQ_IDLE;
                    end else if (step_en) begin
                        if (units_q > 8'd1) begin
                            units_q <= units_q - 8'd1;
                        end else if (last_slot) begin
                            state_q <= SEQ_IDLE;
                            done_q <= 1'b1;
                        end else begin
                            idx_q <= next_idx;
                            units_q <= units_of(sq.slot[next_idx]);
                        end
                    end
                end
                default: begin
                    state_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    assign sq.busy = playing;
    assign sq.done = done_q;
    assign sq.amp = (playing && !cur_slot[haptic_pkg::WAIT_BIT]) ? haptic_pkg::FULL_SCALE : 8'h00;

    property p_seq_empty;
        @(posedge sys_clk) disable iff (!rstn)
        (go_rise && !playing && sq.slot[0] == 8'h00) |=> (done_q && !playing);
    endproperty
    a_seq_empty: assert property (p_seq_empty) else $error("empty queue did not finish");

    property p_seq_abort;
        @(posedge sys_clk) disable iff (!rstn)
        (playing && !sq.go) |=> (!playing && !done_q);
    endproperty
    a_seq_abort: assert property (p_seq_abort) else $error("cancel did not stop sequence");
endmodule

/* File: verilog/haptic_trigger_power_control.sv */
`timescale 1ns/1ps
module haptic_trigger_power_control #(
    parameter int unsigned STEP_CYCLES = haptic_pkg::STEP_CYCLES,
    parameter int unsigned POLL_CYCLES = haptic_pkg::POLL_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic en_pin,
    input wire logic trigger_input_pin,
    input wire logic [7:0] analog_level,
    input wire logic [7:0] supply_sample,
    input wire logic over_temp,
    input wire logic short_detect,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    output logic drive_on,
    output logic [7:0] drive_amp,
    output logic [1:0] power_state
);
    localparam int POLL_W = $clog2(POLL_CYCLES + 1);

    seq_if sq ();

    wave_sequencer #(.STEP_CYCLES(STEP_CYCLES)) u_seq (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .sq(sq)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] mode_q;
    logic [7:0] amp_q;
    logic [7:0][7:0] seq_q;
    logic [4:0][7:0] cfg_q;
    logic [7:0] otp_mem [5];
    logic otp_burned_q;
    logic otp_load_q;
    logic fire_q;
    logic thermal_q;
    logic short_q;
    logic [POLL_W-1:0] poll_q;
    logic [7:0] supply_q;
    logic soft_rst_q;
    logic trig_s1_q;
    logic trig_s2_q;
    logic trig_prev_q;
    logic [7:0] reg_rdata_q;
    logic reg_ack_q;
    logic drive_on_q;
    logic [7:0] drive_amp_q;
    logic [1:0] power_state_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire haptic_pkg::mode_t mode = haptic_pkg::mode_t'(mode_q[2:0]);
    wire standby = mode_q[haptic_pkg::STANDBY_BIT];
    wire halt = thermal_q | short_q;
    wire active = en_pin & ~standby & ~halt;
    wire triggered = (mode == haptic_pkg::MODE_INTERNAL) || (mode == haptic_pkg::MODE_EDGE)
        || (mode == haptic_pkg::MODE_LEVEL);
    wire continuous = (mode == haptic_pkg::MODE_ANALOG) || (mode == haptic_pkg::MODE_AUDIO)
        || (mode == haptic_pkg::MODE_DIRECT);
    wire wr_ok = reg_wr & en_pin & ~soft_rst_q;
    wire rd_ok = reg_rd & en_pin;
    wire seq_hit = (reg_addr >= haptic_pkg::SEQ_FIRST_ADDR)
        && (reg_addr <= haptic_pkg::SEQ_LAST_ADDR);
    wire cfg_hit = (reg_addr >= haptic_pkg::CFG_FIRST_ADDR)
        && (reg_addr <= haptic_pkg::CFG_LAST_ADDR);
    wire [2:0] seq_idx = 3'(reg_addr - haptic_pkg::SEQ_FIRST_ADDR);
    wire [2:0] cfg_idx = 3'(reg_addr - haptic_pkg::CFG_FIRST_ADDR);
    wire wr_mode = wr_ok && (reg_addr == haptic_pkg::MODE_CONTROL_ADDR);
    wire wr_fire = wr_ok && (reg_addr == haptic_pkg::FIRE_CONTROL_ADDR);
    wire wr_amp = wr_ok && (reg_addr == haptic_pkg::DIRECT_AMP_ADDR);
    wire wr_seq = wr_ok && seq_hit;
    wire wr_cfg = wr_ok && cfg_hit;
    wire wr_otp = wr_ok && (reg_addr == haptic_pkg::OTP_CONTROL_ADDR)
        && reg_wdata[haptic_pkg::OTP_PROGRAM_BIT];
    wire trig_rise = trig_s2_q & ~trig_prev_q;

    // ------------------------------------------------------------
    // fire bit
    // ------------------------------------------------------------
    // a host write or pin edge beats a same-cycle completion in fire_d, but sq.go gets no new rise, so the sequencer does not relaunch
    wire fire_d = (!active || !triggered) ? 1'b0 :
        (mode == haptic_pkg::MODE_LEVEL) ? trig_s2_q :
        ((mode == haptic_pkg::MODE_EDGE) && trig_rise) ? ~fire_q :
        wr_fire ? reg_wdata[haptic_pkg::FIRE_BIT] :
        sq.done ? 1'b0 : fire_q;

    // the next fire value drives the sequencer so standby or cancel stops it a cycle sooner
    assign sq.go = fire_d;
    assign sq.slot = seq_q;

    // ------------------------------------------------------------
    // drive and power state
    // ------------------------------------------------------------
    wire drive_on_d = active && (continuous || (triggered && sq.busy));
    wire [7:0] cont_amp = (mode == haptic_pkg::MODE_DIRECT) ? amp_q : analog_level;
    wire [7:0] drive_amp_d = !drive_on_d ? 8'h00 : continuous ? cont_amp : sq.amp;
    wire haptic_pkg::pwr_t power_d = !en_pin ? haptic_pkg::PWR_SHUTDOWN :
        (standby || halt) ? haptic_pkg::PWR_STANDBY :
        drive_on_d ? haptic_pkg::PWR_ACTIVE : haptic_pkg::PWR_READY;

    // ------------------------------------------------------------
    // faults
    // ------------------------------------------------------------
    // shorts can only be seen while the output stage is driving
    wire short_set = short_detect & drive_on_q;
    wire poll_end = short_q && (poll_q == POLL_W'(POLL_CYCLES - 1));
    wire short_restart = poll_end & ~short_detect;
    wire [7:0] fault_status = {6'h00, thermal_q, short_q};
    wire soft_rst_d = (wr_mode & reg_wdata[haptic_pkg::SOFT_RESET_BIT]) | short_restart;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [7:0] rd_mux = (reg_addr == haptic_pkg::FAULT_STATUS_ADDR) ? fault_status :
        (reg_addr == haptic_pkg::MODE_CONTROL_ADDR) ? mode_q :
        (reg_addr == haptic_pkg::DIRECT_AMP_ADDR) ? amp_q :
        seq_hit ? seq_q[seq_idx] :
        (reg_addr == haptic_pkg::FIRE_CONTROL_ADDR) ? {7'h00, fire_q} :
        cfg_hit ? cfg_q[cfg_idx] :
        (reg_addr == haptic_pkg::OTP_CONTROL_ADDR) ? {7'h00, otp_burned_q} :
        (reg_addr == haptic_pkg::SUPPLY_LEVEL_ADDR) ? supply_q : 8'h00;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            trig_s1_q <= trigger_input_pin;
            trig_s2_q <= trig_s1_q;
            trig_prev_q <= trig_s2_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= haptic_pkg::MODE_CONTROL_RESET;
            amp_q <= haptic_pkg::DIRECT_AMP_RESET;
            seq_q <= {8{haptic_pkg::SEQ_RESET}};
            fire_q <= 1'b0;
        end else if (soft_rst_q) begin
            mode_q <= haptic_pkg::MODE_CONTROL_RESET;
            amp_q <= haptic_pkg::DIRECT_AMP_RESET;
            seq_q <= {8{haptic_pkg::SEQ_RESET}};
            fire_q <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_q <= {1'b0, reg_wdata[6:0]};
            end
            if (wr_amp) begin
                amp_q <= reg_wdata;
            end
            if (wr_seq) begin
                seq_q[seq_idx] <= reg_wdata;
            end
            fire_q <= fire_d;
        end
    end

    // otp cells carry no reset: they stand in for fuses that outlive power loss
    always_ff @(posedge sys_clk) begin
        if (wr_otp && !otp_burned_q) begin
            for (int i = 0; i < 5; i++) begin
                otp_mem[i] <= cfg_q[i];
            end
            otp_burned_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= {5{haptic_pkg::CFG_RESET}};
            otp_load_q <= 1'b1;
        end else if (soft_rst_q) begin
            cfg_q <= {5{haptic_pkg::CFG_RESET}};
            otp_load_q <= 1'b1;
        end else begin
            otp_load_q <= 1'b0;
            if (otp_load_q && otp_burned_q) begin
                for (int i = 0; i < 5; i++) begin
                    cfg_q[i] <= otp_mem[i];
                end
            end else if (wr_cfg) begin
                cfg_q[cfg_idx] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            thermal_q <= 1'b0;
            short_q <= 1'b0;
            poll_q <= '0;
            soft_rst_q <= 1'b0;
        end else begin
            thermal_q <= over_temp;
            short_q <= short_set | (short_q & ~short_restart);
            poll_q <= (!short_q || poll_end) ? '0 : poll_q + POLL_W'(1);
            soft_rst_q <= soft_rst_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            supply_q <= haptic_pkg::SUPPLY_RESET;
            reg_rdata_q <= 8'h00;
            reg_ack_q <= 1'b0;
            drive_on_q <= 1'b0;
            drive_amp_q <= 8'h00;
            power_state_q <= haptic_pkg::PWR_SHUTDOWN;
        end else begin
            if (drive_on_q) begin
                supply_q <= supply_sample;
            end
            reg_rdata_q <= rd_ok ? rd_mux : 8'h00;
            reg_ack_q <= reg_wr | reg_rd;
            drive_on_q <= drive_on_d;
            drive_amp_q <= drive_amp_d;
            power_state_q <= power_d;
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign reg_ack = reg_ack_q;
    assign drive_on = drive_on_q;
    assign drive_amp = drive_amp_q;
    assign power_state = power_state_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_fire_write;
        @(posedge sys_clk) disable iff (!rstn)
        (wr_fire && active && mode == haptic_pkg::MODE_INTERNAL)
            |=> (fire_q == $past(reg_wdata[0]));
    endproperty
    a_fire_write: assert property (p_fire_write) else $error("fire write not taken");

    property p_edge_set;
        @(posedge sys_clk) disable iff (!rstn)
        (active && mode == haptic_pkg::MODE_EDGE && trig_rise && !fire_q) |=> fire_q;
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge did not set fire");

    property p_edge_cancel;
        @(posedge sys_clk) disable iff (!rstn)
        (active && mode == haptic_pkg::MODE_EDGE && trig_rise && fire_q) |=> !fire_q;
    endproperty
    a_edge_cancel: assert property (p_edge_cancel) else $error("second edge kept fire");

    property p_edge_fall;
        @(posedge sys_clk) disable iff (!rstn)
        (active && mode == haptic_pkg::MODE_EDGE && !trig_s2_q && trig_prev_q && !wr_fire
            && !sq.done) |=> $stable(fire_q);
    endproperty
    a_edge_fall: assert property (p_edge_fall) else $error("falling edge changed fire");

    property p_level;
        @(posedge sys_clk) disable iff (!rstn)
        (active && mode == haptic_pkg::MODE_LEVEL) |=> (fire_q == $past(trig_s2_q));
    endproperty
    a_level: assert property (p_level) else $error("fire does not follow level");

    property p_sync;
        @(posedge sys_clk) disable iff (!rstn)
        $rose(trigger_input_pin) ##2 1'b1 |-> trig_s2_q;
    endproperty
    a_sync: assert property (p_sync) else $error("trigger not seen after two stages");

    property p_supply;
        @(posedge sys_clk) disable iff (!rstn)
        drive_on_q |=> (supply_q == $past(supply_sample));
    endproperty
    a_supply: assert property (p_supply) else $error("supply level not tracking");

    property p_standby;
        @(posedge sys_clk) disable iff (!rstn)
        (wr_mode && reg_wdata[haptic_pkg::STANDBY_BIT]) |-> ##2 (!drive_on_q && !sq.busy);
    endproperty
    a_standby: assert property (p_standby) else $error("standby did not stop drive");

    property p_soft_reset;
        @(posedge sys_clk) disable iff (!rstn)
        soft_rst_q |=> (mode_q == haptic_pkg::MODE_CONTROL_RESET && !fire_q && amp_q == 8'h00);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

    property p_en_low;
        @(posedge sys_clk) disable iff (!rstn)
        (!en_pin && reg_wr && !soft_rst_q) |=> ($stable(mode_q) && $stable(amp_q));
    endproperty
    a_en_low: assert property (p_en_low) else $error("write while disabled");

    property p_shutdown;
        @(posedge sys_clk) disable iff (!rstn)
        !en_pin |=> (!drive_on_q && power_state_q == haptic_pkg::PWR_SHUTDOWN);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("enable low did not shut down");

    property p_thermal;
        @(posedge sys_clk) disable iff (!rstn)
        over_temp |=> thermal_q ##1 !drive_on_q;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal fault not handled");

    property p_short;
        @(posedge sys_clk) disable iff (!rstn)
        (poll_end && !short_detect) |=> (soft_rst_q && short_q == 1'b0);
    endproperty
    a_short: assert property (p_short) else $error("short clear did not restart");

    property p_analog;
        @(posedge sys_clk) disable iff (!rstn)
        (active && mode == haptic_pkg::MODE_ANALOG)
            |=> (drive_on_q && drive_amp_q == $past(analog_level));
    endproperty
    a_analog: assert property (p_analog) else $error("analog drive not proportional");
endmodule

/* File: verif/host.sv */
`timescale 1ns/1ps
// host side: byte register port plus the trigger pin
module host (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic trig
);
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, trig} = '0;
    end
    // released lines show the inverse so a stale value cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge sys_clk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk) #1;
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge sys_clk) #1;
        d = reg_rdata;
        {reg_rd, reg_addr} = {1'b0, ~a};
    endtask
    // held 100 cycles, 1 us, so the rise is always seen
    task automatic pulse;
        @(posedge sys_clk) #1;
        trig = 1'b1;
        repeat (100) @(posedge sys_clk);
        #1 trig = 1'b0;
    endtask
endmodule

/* File: verif/haptic_trigger_power_control_tb.sv */
`timescale 1ns/1ps
module haptic_trigger_power_control_tb;
    logic sys_clk, rstn, en_pin, trig, over_temp, reg_wr, reg_rd, reg_ack, drive_on;
    logic [7:0] analog_level, supply_sample, reg_addr, reg_wdata, reg_rdata, drive_amp, d, v;
    logic [1:0] power_state;
    logic short_detect;
    int errors = 0;
    int check_count = 0;
    int seed = 32'h88edae22;
    haptic_trigger_power_control #(.STEP_CYCLES(4), .POLL_CYCLES(8))
        u_haptic_trigger_power_control (
        .sys_clk, .rstn, .en_pin, .trigger_input_pin(trig), .analog_level, .supply_sample,
        .over_temp, .short_detect, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_ack, .drive_on, .drive_amp, .power_state);
    host u_host (.sys_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .trig);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // bounded wait on the output stage; a hang ends the run
    task automatic wdrv(input logic e);
        for (int k = 0; k < 80 && drive_on !== e; k++) @(posedge sys_clk) #1;
        #1;
        chk(drive_on, e);
        if (drive_on !== e) test_done();
    endtask
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        {rstn, en_pin, over_temp, short_detect} = '0;
        analog_level = $random(seed);
        supply_sample = $random(seed);
        repeat (5) @(posedge sys_clk);
        #1 rstn = 1'b1;
        u_host.wr(8'h01, 8'h05);
        u_host.rd(8'h01, d);
        chk(d, 8'h00);
        chk(reg_ack, 1'b1);
        chk(power_state, 2'h0);
        en_pin = 1'b1;
        u_host.rd(8'h01, d);
        chk(d, 8'h40);
        u_host.wr(8'h04, 8'h01);
        u_host.wr(8'h01, 8'h00);
        repeat (2) @(posedge sys_clk) #1;
        chk(power_state, 2'h2);
        u_host.wr(8'h0c, 8'h01);
        wdrv(1'b1);
        chk(drive_amp, 8'hff);
        wdrv(1'b0);
        u_host.rd(8'h0c, d);
        chk(d, 8'h00);
        // long effect queued before the pin fires
        u_host.wr(8'h04, 8'h7f);
        u_host.wr(8'h01, 8'h01);
        u_host.pulse();
        chk(drive_on, 1'b1);
        repeat (10) @(posedge sys_clk) #1;
        chk(drive_on, 1'b1);
        u_host.pulse();
        chk(drive_on, 1'b0);
        u_host.rd(8'h0c, d);
        chk(d, 8'h00);
        // level mode: the pin falls long before the queued slot would end
        u_host.wr(8'h01, 8'h02);
        u_host.pulse();
        chk(drive_on, 1'b1);
        wdrv(1'b0);
        u_host.rd(8'h0c, d);
        chk(d, 8'h00);
        v = $random(seed);
        u_host.wr(8'h02, v | 8'h01);
        u_host.wr(8'h01, 8'h05);
        wdrv(1'b1);
        chk(drive_amp, v | 8'h01);
        chk(power_state, 2'h3);
        u_host.rd(8'h21, d);
        chk(d, supply_sample);
        u_host.wr(8'h01, 8'h45);
        wdrv(1'b0);
        chk(power_state, 2'h1);
        u_host.wr(8'h01, 8'h03);
        wdrv(1'b1);
        chk(drive_amp, analog_level);
        u_host.wr(8'h01, 8'h06);
        wdrv(1'b0);
        u_host.wr(8'h01, 8'h04);
        wdrv(1'b1);
        over_temp = 1'b1;
        wdrv(1'b0);
        u_host.rd(8'h00, d);
        chk(d, 8'h02);
        over_temp = 1'b0;
        wdrv(1'b1);
        short_detect = 1'b1;
        wdrv(1'b0);
        u_host.rd(8'h00, d);
        chk(d, 8'h01);
        short_detect = 1'b0;
        repeat (20) @(posedge sys_clk);
        u_host.rd(8'h01, d);
        chk(d, 8'h40);
        u_host.rd(8'h00, d);
        chk(d, 8'h00);
        u_host.wr(8'h01, 8'h04);
        wdrv(1'b1);
        en_pin = 1'b0;
        wdrv(1'b0);
        chk(power_state, 2'h0);
        en_pin = 1'b1;
        u_host.rd(8'h01, d);
        chk(d, 8'h04);
        u_host.wr(8'h01, 8'h85);
        repeat (2) @(posedge sys_clk);
        u_host.rd(8'h01, d);
        chk(d, 8'h40);
        test_done();
    end
endmodule
